// ===== dv/sps_host_model.sv
`default_nettype none
module sps_host_model (
  // Clock
  input wire logic clk,
  // Serial link
  output logic     sif_ck,
  output logic     sif_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sif_ck = 1'b0;
    sif_in = 1'b0;
  end
  // Data changes with the clock low, clock then high for one cycle
  task automatic send_bits(input logic [431:0] w, input int n);
    for (int b = 0; b < n; b++) begin
      @(posedge clk);
      sif_ck <= 1'b0;
      sif_in <= w[b];
      @(posedge clk);
      sif_ck <= 1'b1;
    end
    @(posedge clk);
    sif_ck <= 1'b0;
    sif_in <= !w[n-1];
  endtask
endmodule
`default_nettype wire

// ===== dv/sps_param_store_bench.sv
`default_nettype none
module sps_param_store_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk, rst_b, resync, trs_ref, pin, sif_ck, sif_in;
  logic [431:0] io, rz, dy, hf, vf;
  int           miscompares = 0;
  int           comparisons = 0;
  int           cycles = 0;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  sps_host_model i_sps_host_model (.clk(clk), .sif_ck(sif_ck), .sif_in(sif_in));
  sps_param_store i_sps_param_store (.clk(clk), .rst_b(rst_b), .sif_ck(sif_ck), .sif_in(sif_in),
    .serial_link_resync(resync), .sif_out(), .input_trs_frame_ref(trs_ref), .output_frame_reset_pin(pin),
    .frame_restart(), .group_loaded(), .download_error(), .bank_rows(), .bank_chips(), .bank_refresh(),
    .preread_pixel_count(), .line_total_samples(), .frame_total_lines(), .active_samples_m1(),
    .active_lines_m1(), .active_sample_count(), .active_line_count(), .out_interlaced(), .out_top_field_sel(),
    .out_top_extra_line(), .first_active_line_pos(), .longer_field_sel(), .out_film_rate(), .out_port_mode(),
    .timing_code_insert(), .out_round_narrow(), .proc_round_narrow(), .lsb_mem_en(), .horiz_first_sel(),
    .horiz_decimate(), .vert_decimate(), .horiz_zoom_ratio(), .vert_zoom_ratio(), .horiz_initial_phase(),
    .vert_initial_phase(), .window_first_sample(), .window_last_sample(), .window_first_line(),
    .window_last_line(), .live_first_sample_pos(), .live_last_sample_pos(), .live_first_line_pos(),
    .live_last_line_pos(), .matrix_coef(), .luma_fill_colour(), .blue_diff_fill_colour(),
    .red_diff_fill_colour(), .line_advance(), .horiz_position(), .horiz_coef_word(), .vert_coef_word());
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [431:0] got, input logic [431:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [2:0] code, input logic [431:0] w, input int n);
    i_sps_host_model.send_bits({424'h0, code, 5'h00}, 8);
    i_sps_host_model.send_bits(w, n);
    tick(3);
  endtask
  task automatic pulse_resync();
    @(posedge clk);
    resync <= 1'b1;
    tick(2);
    @(posedge clk);
    resync <= 1'b0;
    tick(1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_io();
    logic il;
    il = !io[20];
    chk(i_sps_param_store.bank_rows[0], io[78] ? 5'h10 : 5'h08);
    chk(i_sps_param_store.bank_rows[1], io[75] ? 5'h10 : 5'h08);
    chk(i_sps_param_store.bank_chips[0], 3'h4 - io[80:79]);
    chk(i_sps_param_store.bank_chips[1], 3'h4 - io[77:76]);
    chk({i_sps_param_store.bank_refresh[0], i_sps_param_store.bank_refresh[1]}, {io[81], io[67]});
    chk(i_sps_param_store.preread_pixel_count, io[74:68]);
    chk(i_sps_param_store.line_total_samples, io[66:55]);
    chk(i_sps_param_store.frame_total_lines, io[54:43]);
    chk({i_sps_param_store.active_samples_m1, i_sps_param_store.active_lines_m1}, io[42:21]);
    chk(i_sps_param_store.active_sample_count, io[42:32] + 12'h001);
    chk(i_sps_param_store.active_line_count, io[31:21] + 12'h001);
    chk(i_sps_param_store.out_interlaced, il);
    chk(i_sps_param_store.out_top_field_sel, il & io[19]);
    chk(i_sps_param_store.out_top_extra_line, il & io[18]);
    chk(i_sps_param_store.first_active_line_pos, io[17:10]);
    chk(i_sps_param_store.longer_field_sel, il & io[43] & io[9]);
    chk(i_sps_param_store.out_film_rate, io[7:6]);
    chk(i_sps_param_store.out_port_mode, io[5:4]);
    chk(i_sps_param_store.timing_code_insert, io[3]);
    chk(i_sps_param_store.out_round_narrow, io[2]);
    chk(i_sps_param_store.lsb_mem_en, !io[1]);
    chk(i_sps_param_store.proc_round_narrow, io[1]);
    @(posedge clk);
    pin <= 1'b1;
    trs_ref <= 1'b0;
    tick(1);
    chk(i_sps_param_store.frame_restart, io[8]);
    @(posedge clk);
    pin <= 1'b0;
    trs_ref <= 1'b1;
    tick(1);
    chk(i_sps_param_store.frame_restart, !io[8]);
  endtask
  task automatic check_rs();
    chk(i_sps_param_store.horiz_zoom_ratio, rz[149:128]);
    chk(i_sps_param_store.vert_zoom_ratio, rz[75:54]);
    chk(i_sps_param_store.horiz_first_sel, rz[151]);
    chk({i_sps_param_store.horiz_decimate, i_sps_param_store.vert_decimate}, {rz[150], rz[76]});
    chk(i_sps_param_store.horiz_initial_phase, rz[127:121]);
    chk(i_sps_param_store.vert_initial_phase, rz[53:47]);
    chk(i_sps_param_store.window_first_sample, rz[120:110]);
    chk(i_sps_param_store.window_last_sample, rz[109:99]);
    chk(i_sps_param_store.window_first_line, rz[46:36]);
    chk(i_sps_param_store.window_last_line, rz[35:25]);
    chk(i_sps_param_store.live_first_sample_pos, rz[98:88]);
    chk(i_sps_param_store.live_last_sample_pos, rz[87:77]);
    chk({i_sps_param_store.live_first_line_pos, i_sps_param_store.live_last_line_pos}, rz[24:3]);
  endtask
  task automatic check_od();
    chk({i_sps_param_store.matrix_coef[0]}, dy[159:147]);
    chk({i_sps_param_store.matrix_coef[8]}, dy[55:43]);
    chk(i_sps_param_store.luma_fill_colour, dy[42:35]);
    chk({i_sps_param_store.blue_diff_fill_colour}, dy[34:27]);
    chk({i_sps_param_store.red_diff_fill_colour}, dy[26:19]);
    chk({i_sps_param_store.line_advance, i_sps_param_store.horiz_position}, dy[18:3]);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    rst_b = 1'b0;
    resync = 1'b0;
    trs_ref = 1'b0;
    pin = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    tick(1);
    chk(i_sps_param_store.bank_rows[1], 5'h08);
    chk(i_sps_param_store.group_loaded, 5'h00);
    for (int k = 0; k < 3; k++) begin
      io = {44{k[1:0]}} ^ {11{8'h5A}};
      send(3'h1, io, 88);
      check_io();
    end
    chk(i_sps_param_store.group_loaded, 5'h01);
    io = {44{2'h3}} ^ {11{8'h5A}};
    rz = {54{8'h69}};
    rz[149:128] = 22'h080000;
    rz[151] = 1'b1;
    rz[88] = 1'b0;
    rz[77] = 1'b1;
    dy = {54{8'h3C}};
    hf = {54{8'h96}};
    vf = {54{8'hC7}};
    send(3'h0, vf, 432);
    i_sps_host_model.send_bits(hf, 344);
    i_sps_host_model.send_bits(dy, 160);
    i_sps_host_model.send_bits(rz, 152);
    i_sps_host_model.send_bits(io, 88);
    tick(3);
    check_io();
    check_rs();
    check_od();
    chk(i_sps_param_store.horiz_coef_word, hf[343:0]);
    chk(i_sps_param_store.vert_coef_word, vf[431:4]);
    chk(i_sps_param_store.group_loaded, 5'h1F);
    rz[149:128] = 22'h07FFFF;
    rz[151] = 1'b0;
    send(3'h2, rz, 152);
    check_rs();
    i_sps_host_model.send_bits({424'h0, 3'h3, 5'h00}, 8);
    i_sps_host_model.send_bits(~dy, 40);
    pulse_resync();
    check_od();
    send(3'h7, ~io, 88);
    chk(i_sps_param_store.download_error, 1'b1);
    chk(i_sps_param_store.sif_out, !dy[39]);
    check_io();
    pulse_resync();
    chk(i_sps_param_store.download_error, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire

// ===== dv/sps_param_store_sva.sv
`default_nettype none
module sps_param_store_sva (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        rst_b,
  // Watched ports
  input wire logic                        serial_link_resync,
  input wire logic [sps_pkg::NGRP-1:0]    group_loaded,
  input wire logic                        download_error,
  input wire logic [sps_pkg::ROWS_W-1:0]  bank_rows [2],
  input wire logic [sps_pkg::CHIPS_W-1:0] bank_chips [2],
  input wire logic [sps_pkg::WIN_W-1:0]   active_samples_m1,
  input wire logic [sps_pkg::WIN_W-1:0]   active_lines_m1,
  input wire logic [sps_pkg::TOT_W-1:0]   active_sample_count,
  input wire logic [sps_pkg::TOT_W-1:0]   active_line_count,
  input wire logic [sps_pkg::TOT_W-1:0]   frame_total_lines,
  input wire logic                        out_interlaced,
  input wire logic                        out_top_extra_line,
  input wire logic                        longer_field_sel,
  input wire logic                        proc_round_narrow,
  input wire logic                        lsb_mem_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence err_held;
    download_error && !serial_link_resync;
  endsequence
  loaded_sticky_a: assert property ((group_loaded & $past(group_loaded)) == $past(group_loaded))
    else $error("group loaded flag dropped");
  err_hold_a: assert property (err_held |=> download_error) else $error("error flag dropped early");
  rows_decode_a: assert property (bank_rows[0] inside {5'h08, 5'h10}) else $error("row count bad");
  chips_decode_a: assert property (bank_chips[1] inside {[3'h1:3'h4]}) else $error("chip count bad");
  sample_count_a: assert property (active_sample_count == active_samples_m1 + 12'h001)
    else $error("sample count bad");
  line_count_a: assert property (active_line_count == active_lines_m1 + 12'h001)
    else $error("line count bad");
  lsb_mem_a: assert property (lsb_mem_en != proc_round_narrow) else $error("lsb memory enable bad");
  longer_field_a: assert property (longer_field_sel |-> out_interlaced && frame_total_lines[0])
    else $error("longer field outside interlace");
  top_extra_a: assert property (out_top_extra_line |-> out_interlaced) else $error("top extra line bad");
endmodule
bind sps_param_store sps_param_store_sva i_sps_param_store_sva (.clk(clk), .rst_b(rst_b),
  .serial_link_resync(serial_link_resync), .group_loaded(group_loaded), .download_error(download_error),
  .bank_rows(bank_rows), .bank_chips(bank_chips), .active_samples_m1(active_samples_m1),
  .active_lines_m1(active_lines_m1), .active_sample_count(active_sample_count),
  .active_line_count(active_line_count), .frame_total_lines(frame_total_lines), .out_interlaced(out_interlaced),
  .out_top_extra_line(out_top_extra_line), .longer_field_sel(longer_field_sel),
  .proc_round_narrow(proc_round_narrow), .lsb_mem_en(lsb_mem_en));
`default_nettype wire

// ===== rtl/sps_load_if.sv
`default_nettype none
interface sps_load_if;
  logic                     bit_valid;
  logic                     bit_data;
  logic [sps_pkg::IDX_W-1:0] bit_index;
  logic [2:0]               grp;
  logic                     grp_done;
  modport rx    (output bit_valid, bit_data, bit_index, grp, grp_done);
  modport store (input  bit_valid, bit_data, bit_index, grp, grp_done);
endinterface
`default_nettype wire

// ===== rtl/sps_param_store.sv
`default_nettype none
module sps_param_store (
  // Clock and reset
  input  wire logic                               clk,
  input  wire logic                               rst_b,
  // Serial download link
  input  wire logic                               sif_ck,
  input  wire logic                               sif_in,
  input  wire logic                               serial_link_resync,
  output logic                                    sif_out,
  // Frame reference
  input  wire logic                               input_trs_frame_ref,
  input  wire logic                               output_frame_reset_pin,
  output logic                                    frame_restart,
  // Status
  output logic [sps_pkg::NGRP-1:0]                group_loaded,
  output logic                                    download_error,
  // Memory control
  output logic [sps_pkg::ROWS_W-1:0]              bank_rows [2],
  output logic [sps_pkg::CHIPS_W-1:0]             bank_chips [2],
  output logic                                    bank_refresh [2],
  output logic [sps_pkg::PRE_W-1:0]               preread_pixel_count,
  // Output raster
  output logic [sps_pkg::TOT_W-1:0]               line_total_samples,
  output logic [sps_pkg::TOT_W-1:0]               frame_total_lines,
  output logic [sps_pkg::WIN_W-1:0]               active_samples_m1,
  output logic [sps_pkg::WIN_W-1:0]               active_lines_m1,
  output logic [sps_pkg::TOT_W-1:0]               active_sample_count,
  output logic [sps_pkg::TOT_W-1:0]               active_line_count,
  output logic                                    out_interlaced,
  output logic                                    out_top_field_sel,
  output logic                                    out_top_extra_line,
  output logic [sps_pkg::POS_W-1:0]               first_active_line_pos,
  output logic                                    longer_field_sel,
  output sps_pkg::sps_film_t                      out_film_rate,
  output sps_pkg::sps_omode_t                     out_port_mode,
  output logic                                    timing_code_insert,
  output logic                                    out_round_narrow,
  output logic                                    proc_round_narrow,
  output logic                                    lsb_mem_en,
  // Resizing
  output logic                                    horiz_first_sel,
  output logic                                    horiz_decimate,
  output logic                                    vert_decimate,
  output logic [sps_pkg::ZOOM_W-1:0]              horiz_zoom_ratio,
  output logic [sps_pkg::ZOOM_W-1:0]              vert_zoom_ratio,
  output logic [sps_pkg::PHASE_W-1:0]             horiz_initial_phase,
  output logic [sps_pkg::PHASE_W-1:0]             vert_initial_phase,
  output logic [sps_pkg::WIN_W-1:0]               window_first_sample,
  output logic [sps_pkg::WIN_W-1:0]               window_last_sample,
  output logic [sps_pkg::WIN_W-1:0]               window_first_line,
  output logic [sps_pkg::WIN_W-1:0]               window_last_line,
  output logic [sps_pkg::WIN_W-1:0]               live_first_sample_pos,
  output logic [sps_pkg::WIN_W-1:0]               live_last_sample_pos,
  output logic [sps_pkg::WIN_W-1:0]               live_first_line_pos,
  output logic [sps_pkg::WIN_W-1:0]               live_last_line_pos,
  // Output processing
  output logic signed [sps_pkg::COEF_W-1:0]       matrix_coef [sps_pkg::N_COEF],
  output logic [sps_pkg::BG_W-1:0]                luma_fill_colour,
  output logic signed [sps_pkg::BG_W-1:0]         blue_diff_fill_colour,
  output logic signed [sps_pkg::BG_W-1:0]         red_diff_fill_colour,
  output logic [sps_pkg::ADV_W-1:0]               line_advance,
  output logic [sps_pkg::TOT_W-1:0]               horiz_position,
  // Filter coefficient banks
  output logic [343:0]                            horiz_coef_word,
  output logic [sps_pkg::VCOEF_W-1:0]             vert_coef_word
);
  ////////////////////////////////////////////////////////////////////////////////
  // Serial receiver
  sps_load_if ld ();

  sps_serial_rx u_rx (
    .clk                (clk),
    .rst_b              (rst_b),
    .sif_ck             (sif_ck),
    .sif_in             (sif_in),
    .serial_link_resync (serial_link_resync),
    .ld                 (ld.rx),
    .cmd_err            (download_error)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Shadow and live words
  logic [sps_pkg::AP_W-1:0] shadow;
  logic [sps_pkg::AP_W-1:0] live;
  logic [sps_pkg::AP_W-1:0] commit_mask;
  logic                     commit;
  logic [2:0]               commit_grp;

  // Live word changes only once a whole group has arrived
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shadow <= '0;
    end else if (ld.bit_valid) begin
      shadow[ld.bit_index] <= ld.bit_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      commit     <= 1'b0;
      commit_grp <= 3'h0;
    end else begin
      commit     <= ld.grp_done;
      commit_grp <= ld.grp;
    end
  end

  // Mask covers the group minus its low fill bits
  always_comb begin
    commit_mask = ({sps_pkg::AP_W{1'b1}} >> (sps_pkg::AP_W - sps_pkg::GRP_W[commit_grp]
                  + sps_pkg::GRP_FILL[commit_grp]))
                  << (sps_pkg::GRP_OFF[commit_grp] + sps_pkg::GRP_FILL[commit_grp]);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      live <= '0;
    end else if (commit) begin
      live <= (live & ~commit_mask) | (shadow & commit_mask);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      group_loaded <= '0;
    end else if (commit) begin
      group_loaded[commit_grp] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sif_out <= 1'b0;
    end else if (ld.bit_valid) begin
      sif_out <= ld.bit_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Group views
  logic [87:0]  io_w;
  logic [151:0] rz_w;
  logic [159:0] dy_w;
  logic [431:0] vf_w;

  assign io_w            = live[sps_pkg::GRP_OFF[0] +: 88];
  assign rz_w            = live[sps_pkg::GRP_OFF[1] +: 152];
  assign dy_w            = live[sps_pkg::GRP_OFF[2] +: 160];
  assign horiz_coef_word = live[sps_pkg::GRP_OFF[3] +: 344];
  assign vf_w            = live[sps_pkg::GRP_OFF[4] +: 432];
  assign vert_coef_word  = vf_w[431:4];

  ////////////////////////////////////////////////////////////////////////////////
  // Memory control
  for (genvar b = 0; b < 2; b++) begin : g_bank
    assign bank_rows[b]    = io_w[sps_pkg::IO_MODE16[b]] ? sps_pkg::ROWS_LONG
                                                         : sps_pkg::ROWS_SHORT;
    assign bank_chips[b]   = sps_pkg::CHIPS_MAX - {1'b0, io_w[sps_pkg::IO_CHIPS[b] +: 2]};
    assign bank_refresh[b] = io_w[sps_pkg::IO_REFR[b]];
  end

  assign preread_pixel_count = io_w[sps_pkg::IO_PREREAD +: sps_pkg::PRE_W];

  ////////////////////////////////////////////////////////////////////////////////
  // Output raster
  assign line_total_samples  = io_w[sps_pkg::IO_HTOT +: sps_pkg::TOT_W];
  assign frame_total_lines   = io_w[sps_pkg::IO_VTOT +: sps_pkg::TOT_W];
  assign active_samples_m1   = io_w[sps_pkg::IO_HACT +: sps_pkg::WIN_W];
  assign active_lines_m1     = io_w[sps_pkg::IO_VACT +: sps_pkg::WIN_W];
  assign active_sample_count = {1'b0, active_samples_m1} + 12'h001;
  assign active_line_count   = {1'b0, active_lines_m1} + 12'h001;
  assign out_interlaced      = ~io_w[sps_pkg::IO_SCAN];

  // Field controls only matter for interlaced output
  assign out_top_field_sel     = out_interlaced & io_w[sps_pkg::IO_TOP_FLD];
  assign out_top_extra_line    = out_interlaced & io_w[sps_pkg::IO_TOP_EXTRA];
  assign first_active_line_pos = io_w[sps_pkg::IO_VACT_POS +: sps_pkg::POS_W];
  assign longer_field_sel      = out_interlaced & frame_total_lines[0]
                                 & io_w[sps_pkg::IO_LONGER_FLD];

  assign frame_restart = io_w[sps_pkg::IO_REF_SEL] ? output_frame_reset_pin
                                                   : input_trs_frame_ref;

  assign out_film_rate      = sps_pkg::sps_film_t'(io_w[sps_pkg::IO_OUT_FILM +: 2]);
  assign out_port_mode      = sps_pkg::sps_omode_t'(io_w[sps_pkg::IO_OUT_MODE +: 2]);
  assign timing_code_insert = io_w[sps_pkg::IO_TRS_INSERT];
  assign out_round_narrow   = io_w[sps_pkg::IO_OUT_NARROW];
  assign proc_round_narrow  = io_w[sps_pkg::IO_PROC_NARROW];
  assign lsb_mem_en         = ~io_w[sps_pkg::IO_PROC_NARROW];

  ////////////////////////////////////////////////////////////////////////////////
  // Resizing
  // Horizontal-first is taken as sent; the host keeps it in step with the ratio
  assign horiz_first_sel  = rz_w[sps_pkg::RZ_HFIRST];
  assign horiz_decimate   = rz_w[sps_pkg::RZ_HDEC];
  assign vert_decimate    = rz_w[sps_pkg::RZ_VDEC];
  assign horiz_zoom_ratio = rz_w[sps_pkg::RZ_HZOOM +: sps_pkg::ZOOM_W];
  assign vert_zoom_ratio  = rz_w[sps_pkg::RZ_VZOOM +: sps_pkg::ZOOM_W];

  assign horiz_initial_phase = rz_w[sps_pkg::RZ_HPHASE +: sps_pkg::PHASE_W];
  assign vert_initial_phase  = rz_w[sps_pkg::RZ_VPHASE +: sps_pkg::PHASE_W];
  assign window_first_sample = rz_w[sps_pkg::RZ_IHSTART +: sps_pkg::WIN_W];
  assign window_last_sample  = rz_w[sps_pkg::RZ_IHSTOP +: sps_pkg::WIN_W];
  assign window_first_line   = rz_w[sps_pkg::RZ_IVSTART +: sps_pkg::WIN_W];
  assign window_last_line    = rz_w[sps_pkg::RZ_IVSTOP +: sps_pkg::WIN_W];

  // Parity of the live span is the host's duty and passes unchanged
  assign live_first_sample_pos = rz_w[sps_pkg::RZ_OHSTART +: sps_pkg::WIN_W];
  assign live_last_sample_pos  = rz_w[sps_pkg::RZ_OHSTOP +: sps_pkg::WIN_W];
  assign live_first_line_pos   = rz_w[sps_pkg::RZ_OVSTART +: sps_pkg::WIN_W];
  assign live_last_line_pos    = rz_w[sps_pkg::RZ_OVSTOP +: sps_pkg::WIN_W];

  ////////////////////////////////////////////////////////////////////////////////
  // Output processing
  // Index 0..8 is G1 G2 G3 B1 B2 B3 R1 R2 R3
  for (genvar k = 0; k < sps_pkg::N_COEF; k++) begin : g_coef
    assign matrix_coef[k] = dy_w[sps_pkg::DY_MATRIX + sps_pkg::COEF_W * (sps_pkg::N_COEF - 1 - k)
                                 +: sps_pkg::COEF_W];
  end

  assign luma_fill_colour      = dy_w[sps_pkg::DY_Y +: sps_pkg::BG_W];
  assign blue_diff_fill_colour = dy_w[sps_pkg::DY_CB +: sps_pkg::BG_W];
  assign red_diff_fill_colour  = dy_w[sps_pkg::DY_CR +: sps_pkg::BG_W];
  assign line_advance          = dy_w[sps_pkg::DY_LINE_ADV +: sps_pkg::ADV_W];
  assign horiz_position        = dy_w[sps_pkg::DY_HPOS +: sps_pkg::TOT_W];
endmodule
`default_nettype wire

// ===== rtl/sps_pkg.sv
`default_nettype none
package sps_pkg;
  // Whole download word, all five groups concatenated
  localparam int AP_W  = 1176;
  localparam int IDX_W = 11;
  localparam int NGRP  = 5;
  localparam int CMD_W = 8;
  localparam int CMD_PAD = 5;

  // Group order: IO, resize, dynamic, HF, VF
  typedef enum logic [2:0] {SPS_G_IO, SPS_G_RZ, SPS_G_DY, SPS_G_HF, SPS_G_VF} sps_grp_t;
  localparam int GRP_W    [NGRP] = '{88, 152, 160, 344, 432};
  localparam int GRP_OFF  [NGRP] = '{1088, 936, 776, 432, 0};
  localparam int GRP_FILL [NGRP] = '{1, 3, 3, 0, 4};

  // Command code in the top three bits of the command byte
  localparam logic [2:0] CMD_ALL  = 3'h0;
  localparam logic [2:0] CMD_LAST = 3'h5;

  // Format / static word fields (bit positions inside the group)
  localparam int IO_PROC_NARROW = 1;
  localparam int IO_OUT_NARROW  = 2;
  localparam int IO_TRS_INSERT  = 3;
  localparam int IO_OUT_MODE    = 4;
  localparam int IO_OUT_FILM    = 6;
  localparam int IO_REF_SEL     = 8;
  localparam int IO_LONGER_FLD  = 9;
  localparam int IO_VACT_POS    = 10;
  localparam int IO_TOP_EXTRA   = 18;
  localparam int IO_TOP_FLD     = 19;
  localparam int IO_SCAN        = 20;
  localparam int IO_VACT        = 21;
  localparam int IO_HACT        = 32;
  localparam int IO_VTOT        = 43;
  localparam int IO_HTOT        = 55;
  localparam int IO_PREREAD     = 68;
  localparam int IO_MODE16 [2]  = '{78, 75};
  localparam int IO_CHIPS  [2]  = '{79, 76};
  localparam int IO_REFR   [2]  = '{81, 67};

  // Resize word fields
  localparam int RZ_OVSTOP  = 3;
  localparam int RZ_OVSTART = 14;
  localparam int RZ_IVSTOP  = 25;
  localparam int RZ_IVSTART = 36;
  localparam int RZ_VPHASE  = 47;
  localparam int RZ_VZOOM   = 54;
  localparam int RZ_VDEC    = 76;
  localparam int RZ_OHSTOP  = 77;
  localparam int RZ_OHSTART = 88;
  localparam int RZ_IHSTOP  = 99;
  localparam int RZ_IHSTART = 110;
  localparam int RZ_HPHASE  = 121;
  localparam int RZ_HZOOM   = 128;
  localparam int RZ_HDEC    = 150;
  localparam int RZ_HFIRST  = 151;

  // Dynamic output word fields; matrix G1 is the top coefficient
  localparam int DY_HPOS     = 3;
  localparam int DY_LINE_ADV = 15;
  localparam int DY_CR       = 19;
  localparam int DY_CB       = 27;
  localparam int DY_Y        = 35;
  localparam int DY_MATRIX   = 43;
  localparam int N_COEF      = 9;

  // Field widths
  localparam int WIN_W   = 11;
  localparam int PHASE_W = 7;
  localparam int ZOOM_W  = 22;
  localparam int TOT_W   = 12;
  localparam int COEF_W  = 13;
  localparam int BG_W    = 8;
  localparam int POS_W   = 8;
  localparam int ADV_W   = 4;
  localparam int PRE_W   = 7;
  localparam int ROWS_W  = 5;
  localparam int CHIPS_W = 3;
  localparam int VCOEF_W = 428;

  // Decoded constants
  localparam logic [4:0] ROWS_SHORT = 5'h08;
  localparam logic [4:0] ROWS_LONG  = 5'h10;
  localparam logic [2:0] CHIPS_MAX  = 3'h4;

  typedef enum logic [1:0] {SPS_FILM_32, SPS_FILM_22, SPS_FILM_NATIVE, SPS_FILM_NONE} sps_film_t;
  typedef enum logic [1:0] {SPS_OM_GBR444, SPS_OM_YCC444, SPS_OM_422_SINGLE, SPS_OM_422_DUAL} sps_omode_t;
endpackage
`default_nettype wire

// ===== rtl/sps_serial_rx.sv
`default_nettype none
module sps_serial_rx (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst_b,
  // Serial link
  input  wire logic  sif_ck,
  input  wire logic  sif_in,
  input  wire logic  serial_link_resync,
  // Loader side
  sps_load_if.rx     ld,
  output logic       cmd_err
);
  typedef enum logic [1:0] {SPS_ST_CMD, SPS_ST_DATA, SPS_ST_HALT} sps_rx_state_t;

  sps_rx_state_t                    state;
  logic                             ck_q;
  logic                             ck_rise;
  logic [sps_pkg::CMD_W-1:0]        cmd;
  logic [2:0]                       cmd_cnt;
  logic [sps_pkg::CMD_W-1:0]        cmd_full;
  logic [2:0]                       grp;
  logic                             all_groups;
  logic [sps_pkg::IDX_W-1:0]        cnt;
  logic                             last_bit;

  assign ck_rise  = sif_ck & ~ck_q;
  assign cmd_full = {sif_in, cmd[sps_pkg::CMD_W-1:1]};
  assign last_bit = (32'(cnt) == sps_pkg::GRP_W[grp] - 1);

  assign ld.bit_valid = (state == SPS_ST_DATA) && ck_rise && !serial_link_resync;
  assign ld.bit_data  = sif_in;
  assign ld.bit_index = sps_pkg::IDX_W'(sps_pkg::GRP_OFF[grp] + 32'(cnt));
  assign ld.grp       = grp;
  assign ld.grp_done  = ld.bit_valid && last_bit;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ck_q <= 1'b0;
    end else begin
      ck_q <= sif_ck;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || serial_link_resync) begin
      state      <= SPS_ST_CMD;
      cmd        <= 8'h00;
      cmd_cnt    <= 3'h0;
      grp        <= 3'h0;
      all_groups <= 1'b0;
      cnt        <= 11'h000;
      cmd_err    <= 1'b0;
    end else if (ck_rise) begin
      unique case (state)
        SPS_ST_CMD: begin
          cmd     <= cmd_full;
          cmd_cnt <= cmd_cnt + 3'h1;
          cnt     <= 11'h000;
          if (cmd_cnt == 3'h7) begin
            if (cmd_full[sps_pkg::CMD_PAD-1:0] != 5'h00 ||
                cmd_full[7:5] > sps_pkg::CMD_LAST) begin
              state   <= SPS_ST_HALT;
              cmd_err <= 1'b1;
            end else begin
              state      <= SPS_ST_DATA;
              all_groups <= (cmd_full[7:5] == sps_pkg::CMD_ALL);
              // Full download starts with the lowest word, the vertical bank
              grp        <= (cmd_full[7:5] == sps_pkg::CMD_ALL) ? 3'(sps_pkg::SPS_G_VF) : cmd_full[7:5] - 3'h1;
            end
          end
        end
        SPS_ST_DATA: begin
          if (last_bit) begin
            cnt <= 11'h000;
            if (all_groups && grp != 3'h0) begin
              grp <= grp - 3'h1;
            end else begin
              state <= SPS_ST_CMD;
            end
          end else begin
            cnt <= cnt + 11'h001;
          end
        end
        SPS_ST_HALT: begin
          state <= SPS_ST_HALT;
        end
      endcase
    end
  end

endmodule
`default_nettype wire
